// *** hdl/pfs_consts.svh ***
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// Register select codes
`define PFS_SEL_STATUS   2'h0
`define PFS_SEL_THERMAL  2'h1
`define PFS_SEL_PCOUNT   2'h2
`define PFS_SEL_ENABLE   2'h3

// Field positions
`define PFS_ST_GUAR_BIT  0
`define PFS_ST_EXC_BIT   2
`define PFS_TH_CUR_ST    12
`define PFS_TH_CUR_LOG   13
`define PFS_TH_XD_ST     14
`define PFS_TH_XD_LOG    15
`define PFS_EN_GUAR_BIT  0
`define PFS_EN_EXC_BIT   1

// Reset values
`define PFS_ZERO64       64'h0000_0000_0000_0000
`define PFS_EN_RESET     2'h0

// Timing
`define PFS_CLK_HZ       20000000
`define PFS_TICK_US      1000
`define PFS_TICK_CYCLES  ((`PFS_CLK_HZ / 1000000) * `PFS_TICK_US)
`define PFS_ONE_SEC_MS   1000
`define PFS_EXC_MS       10
`define PFS_TICK_W       15
`define PFS_MS_W         10

`endif

// *** hdl/pfs_event_gate.sv ***
`timescale 1ns/1ps
`include "pfs_consts.svh"

module pfs_event_gate #(
  parameter logic [`PFS_MS_W-1:0] SUSTAIN_MS = 10'h001,
  parameter logic [`PFS_MS_W-1:0] HOLDOFF_MS = 10'h3e8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Timing and condition
  input  wire logic tick_ms,
  input  wire logic cond,
  // Qualified event
  output logic      fire_q
);
  import pfs_pkg::*;

  pfs_gate_state_t        state_q;
  pfs_gate_state_t        state_d;
  logic [`PFS_MS_W-1:0]   cnt_q;
  logic [`PFS_MS_W-1:0]   cnt_d;
  logic [`PFS_MS_W-1:0]   cnt_inc;
  logic                   fire_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_inc = cnt_q + `PFS_MS_W'(1);
    state_d = state_q;
    cnt_d   = cnt_q;
    fire_d  = 1'b0;
    case (state_q)
      PFS_GATE_IDLE: begin
        cnt_d = '0;
        if (cond) begin
          state_d = PFS_GATE_QUALIFY;
        end
      end
      PFS_GATE_QUALIFY: begin
        if (!cond) begin
          state_d = PFS_GATE_IDLE;
        end else if (tick_ms) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= SUSTAIN_MS) begin
            fire_d  = 1'b1;
            cnt_d   = '0;
            state_d = PFS_GATE_HOLDOFF;
          end
        end
      end
      PFS_GATE_HOLDOFF: begin
        if (tick_ms) begin
          cnt_d = cnt_inc;
          if (cnt_inc >= HOLDOFF_MS) begin
            state_d = PFS_GATE_IDLE;
          end
        end
      end
      default: begin
        state_d = PFS_GATE_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= PFS_GATE_IDLE;
      cnt_q   <= '0;
      fire_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      fire_q  <= fire_d;
    end
  end

endmodule : pfs_event_gate

// *** hdl/pfs_pkg.sv ***
package pfs_pkg;

  typedef enum logic [1:0] {
    PFS_MSR_STATUS  = 2'h0,
    PFS_MSR_THERMAL = 2'h1,
    PFS_MSR_PCOUNT  = 2'h2,
    PFS_MSR_ENABLE  = 2'h3
  } pfs_msr_sel_t;

  typedef enum logic [1:0] {
    PFS_GATE_IDLE    = 2'b00,
    PFS_GATE_QUALIFY = 2'b01,
    PFS_GATE_HOLDOFF = 2'b10
  } pfs_gate_state_t;

endpackage : pfs_pkg

// *** hdl/pfs_top.sv ***
`timescale 1ns/1ps
`include "pfs_consts.svh"

module pfs_top #(
  parameter logic [`PFS_TICK_W-1:0] MS_CYCLES       = `PFS_TICK_W'(`PFS_TICK_CYCLES),
  parameter logic                   NOTIFY_SUPPORTED = 1'b1
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register access port
  input  wire pfs_pkg::pfs_msr_sel_t msr_sel,
  input  wire logic                 msr_wr,
  input  wire logic                 msr_rd,
  input  wire logic [63:0]          msr_wdata,
  output logic      [63:0]          msr_rdata_q,
  output logic                      msr_rvalid_q,
  // Performance levels from the controller
  input  wire logic [7:0]           guaranteed_perf,
  input  wire logic [7:0]           min_perf_req,
  input  wire logic [7:0]           delivered_perf,
  // Cycle qualifiers
  input  wire logic                 actual_cycle,
  input  wire logic                 productive_cycle,
  // Limit indications from other domains
  input  wire logic                 current_limit_in,
  input  wire logic                 cross_domain_limit_in,
  // Notification and capability
  output logic                      thermal_lvt_req_q,
  output logic                      notify_cap_q,
  output logic      [7:0]           reported_guaranteed_q
);
  import pfs_pkg::*;

  // Millisecond divider
  logic [`PFS_TICK_W-1:0] div_q;
  logic [`PFS_TICK_W-1:0] div_d;
  logic                   tick_q;
  logic                   tick_d;

  // Limit synchronisers
  logic [1:0]             cur_sync_q;
  logic [1:0]             xd_sync_q;
  logic [1:0]             cur_sync_d;
  logic [1:0]             xd_sync_d;
  logic                   cur_live;
  logic                   xd_live;

  // Event qualification
  logic                   primed_q;
  logic                   primed_d;
  logic [7:0]             rep_guar_d;
  logic                   guar_cond;
  logic                   exc_cond;
  logic                   guar_fire;
  logic                   exc_fire;

  // Register state
  logic                   st_guar_q;
  logic                   st_guar_d;
  logic                   st_exc_q;
  logic                   st_exc_d;
  logic                   cur_log_q;
  logic                   cur_log_d;
  logic                   xd_log_q;
  logic                   xd_log_d;
  logic [1:0]             en_q;
  logic [1:0]             en_d;
  logic [63:0]            pcount_q;
  logic [63:0]            pcount_d;

  // Access decode
  logic                   wr_status;
  logic                   wr_thermal;
  logic                   wr_enable;
  logic                   clr_guar;
  logic                   clr_exc;
  logic                   clr_cur;
  logic                   clr_xd;

  // Notification
  logic                   guar_rise;
  logic                   exc_rise;
  logic                   lvt_d;
  logic                   cap_d;
  logic [63:0]            rdata_d;
  logic                   rvalid_d;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  // One-cycle enable pulse every MS_CYCLES clocks
  always_comb begin
    tick_d = 1'b0;
    div_d  = div_q + `PFS_TICK_W'(1);
    if (div_q >= MS_CYCLES - `PFS_TICK_W'(1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit input synchronisers; pins pass two flops before use
  always_comb begin
    cur_sync_d = {cur_sync_q[0], current_limit_in};
    xd_sync_d  = {xd_sync_q[0], cross_domain_limit_in};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_sync_q <= 2'h0;
      xd_sync_q  <= 2'h0;
    end else begin
      cur_sync_q <= cur_sync_d;
      xd_sync_q  <= xd_sync_d;
    end
  end

  assign cur_live = cur_sync_q[1];
  assign xd_live  = xd_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification
  // Reported level is captured from the live level just after reset release
  always_comb begin
    primed_d   = 1'b1;
    rep_guar_d = reported_guaranteed_q;
    if (!primed_q || guar_fire) begin
      rep_guar_d = guaranteed_perf;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primed_q              <= 1'b0;
      reported_guaranteed_q <= 8'h00;
    end else begin
      primed_q              <= primed_d;
      reported_guaranteed_q <= rep_guar_d;
    end
  end

  // Compared against the last reported level, not the previous cycle
  assign guar_cond = primed_q && (guaranteed_perf != reported_guaranteed_q);
  // Floor above delivered keeps this true, so the gate refires about each second; the set flag stops new reports
  assign exc_cond  = (delivered_perf < min_perf_req);

  // A fire on a set flag still restarts the holdoff
  pfs_event_gate #(
    .SUSTAIN_MS (`PFS_MS_W'(`PFS_ONE_SEC_MS)),
    .HOLDOFF_MS (`PFS_MS_W'(`PFS_ONE_SEC_MS))
  ) u_guar_gate (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick_ms (tick_q),
    .cond    (guar_cond),
    .fire_q  (guar_fire)
  );

  pfs_event_gate #(
    .SUSTAIN_MS (`PFS_MS_W'(`PFS_EXC_MS)),
    .HOLDOFF_MS (`PFS_MS_W'(`PFS_ONE_SEC_MS))
  ) u_exc_gate (
    .clk     (clk),
    .rst_b   (rst_b),
    .tick_ms (tick_q),
    .cond    (exc_cond),
    .fire_q  (exc_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; only a written 0 clears a sticky bit
  // Counter and live bits have no write path
  assign wr_status  = msr_wr && (msr_sel == PFS_MSR_STATUS);
  assign wr_thermal = msr_wr && (msr_sel == PFS_MSR_THERMAL);
  assign wr_enable  = msr_wr && (msr_sel == PFS_MSR_ENABLE);
  assign clr_guar   = wr_status  && !msr_wdata[`PFS_ST_GUAR_BIT];
  assign clr_exc    = wr_status  && !msr_wdata[`PFS_ST_EXC_BIT];
  assign clr_cur    = wr_thermal && !msr_wdata[`PFS_TH_CUR_LOG];
  assign clr_xd     = wr_thermal && !msr_wdata[`PFS_TH_XD_LOG];

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, logs and enables; a set beats a clear in the same cycle
  always_comb begin
    st_guar_d = guar_fire | (st_guar_q & ~clr_guar);
    st_exc_d  = exc_fire  | (st_exc_q  & ~clr_exc);
    cur_log_d = cur_live  | (cur_log_q & ~clr_cur);
    xd_log_d  = xd_live   | (xd_log_q  & ~clr_xd);
    // Enable bits above bit 1 are dropped on write
    en_d      = en_q;
    if (wr_enable) begin
      en_d = msr_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_guar_q <= 1'b0;
      st_exc_q  <= 1'b0;
      cur_log_q <= 1'b0;
      xd_log_q  <= 1'b0;
      en_q      <= `PFS_EN_RESET;
    end else begin
      st_guar_q <= st_guar_d;
      st_exc_q  <= st_exc_d;
      cur_log_q <= cur_log_d;
      xd_log_q  <= xd_log_d;
      en_q      <= en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Productive cycle counter, free of any enable
  // Wraps to zero after all ones
  always_comb begin
    pcount_d = pcount_q;
    if (actual_cycle && productive_cycle) begin
      pcount_d = pcount_q + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pcount_q <= `PFS_ZERO64;
    end else begin
      pcount_q <= pcount_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Notification through the thermal vector entry
  // A fire counts as a new rise when the flag was clear or is cleared now
  assign guar_rise = guar_fire && (!st_guar_q || clr_guar);
  assign exc_rise  = exc_fire  && (!st_exc_q  || clr_exc);

  always_comb begin
    lvt_d = NOTIFY_SUPPORTED &&
            ((guar_rise && en_q[`PFS_EN_GUAR_BIT]) ||
             (exc_rise  && en_q[`PFS_EN_EXC_BIT]));
    cap_d = NOTIFY_SUPPORTED;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thermal_lvt_req_q <= 1'b0;
      notify_cap_q      <= 1'b0;
    end else begin
      thermal_lvt_req_q <= lvt_d;
      notify_cap_q      <= cap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // Reserved and unselected bits stay zero from the default
  always_comb begin
    rdata_d  = `PFS_ZERO64;
    rvalid_d = msr_rd;
    if (msr_rd) begin
      case (msr_sel)
        PFS_MSR_STATUS: begin
          rdata_d[`PFS_ST_GUAR_BIT] = st_guar_q;
          rdata_d[`PFS_ST_EXC_BIT]  = st_exc_q;
        end
        PFS_MSR_THERMAL: begin
          rdata_d[`PFS_TH_CUR_ST]  = cur_live;
          rdata_d[`PFS_TH_CUR_LOG] = cur_log_q;
          rdata_d[`PFS_TH_XD_ST]   = xd_live;
          rdata_d[`PFS_TH_XD_LOG]  = xd_log_q;
        end
        PFS_MSR_PCOUNT: begin
          rdata_d = pcount_q;
        end
        PFS_MSR_ENABLE: begin
          rdata_d[1:0] = en_q;
        end
        default: begin
          rdata_d = `PFS_ZERO64;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msr_rdata_q  <= `PFS_ZERO64;
      msr_rvalid_q <= 1'b0;
    end else begin
      msr_rdata_q  <= rdata_d;
      msr_rvalid_q <= rvalid_d;
    end
  end

endmodule : pfs_top

// *** test/perf_feedback_status_notify_tb_top.sv ***
`timescale 1ns/1ps
`include "pfs_consts.svh"
module perf_feedback_status_notify_tb_top;
  import pfs_pkg::*;
  localparam logic [`PFS_TICK_W-1:0] MS = 15'h0004;
  logic         clk, rst_b, wr, rd, act, prod, cur, xd, rv, lvt, cap;
  pfs_msr_sel_t sel;
  logic [63:0]  wd, rdat, rnd;
  logic [7:0]   gp, mp, dp, rg;
  logic         m_guar, m_exc;
  logic [63:0]  m_cnt;
  int           n_lvt, n_errors, comparisons;
  pfs_top #(.MS_CYCLES(MS), .NOTIFY_SUPPORTED(1'b1)) dut (
    .clk(clk), .rst_b(rst_b), .msr_sel(sel), .msr_wr(wr), .msr_rd(rd), .msr_wdata(wd),
    .msr_rdata_q(rdat), .msr_rvalid_q(rv), .guaranteed_perf(gp), .min_perf_req(mp),
    .delivered_perf(dp), .actual_cycle(act), .productive_cycle(prod), .current_limit_in(cur),
    .cross_domain_limit_in(xd), .thermal_lvt_req_q(lvt), .notify_cap_q(cap),
    .reported_guaranteed_q(rg));
  ////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Entered and left one delay after a rising edge
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic wr_reg(pfs_msr_sel_t s, logic [63:0] d);
    sel = s;
    wd = d;
    wr = 1'b1;
    wait_cyc(1);
    wr = 1'b0;
    wait_cyc(1);
  endtask : wr_reg
  task automatic rd_chk(pfs_msr_sel_t s, logic [63:0] e, string nm);
    sel = s;
    rd = 1'b1;
    wait_cyc(1);
    rd = 1'b0;
    check("rvalid", rv, 1'b1);
    check(nm, rdat, e);
    wait_cyc(1);
  endtask : rd_chk
  task automatic wait_lvt(int n, int max);
    int k;
    k = 0;
    while (n_lvt < n && k < max) begin
      wait_cyc(1);
      k++;
    end
    check("lvt count", n_lvt, n);
  endtask : wait_lvt
  task automatic chk_zero;
    for (int s = 0; s < 4; s++) rd_chk(pfs_msr_sel_t'(s), 64'h0, "reset value");
  endtask : chk_zero
  function automatic logic [63:0] st_exp();
    return {61'h0, m_exc, 1'b0, m_guar};
  endfunction : st_exp
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) if (lvt === 1'b1) n_lvt++;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 40000);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst_b, wr, rd, act, prod, cur, xd, m_guar, m_exc} = '0;
    sel = PFS_MSR_STATUS;
    wd = '0;
    m_cnt = '0;
    gp = 8'h40;
    mp = 8'h20;
    dp = 8'h30;
    void'($urandom(13));
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    wait_cyc(1);
    chk_zero();
    check("capability", cap, 1'b1);
    check("reported", rg, gp);
    // Ones into sticky, counter and reserved places
    wr_reg(PFS_MSR_STATUS, '1);
    rd_chk(PFS_MSR_STATUS, st_exp(), "status ones");
    wr_reg(PFS_MSR_PCOUNT, '1);
    rd_chk(PFS_MSR_PCOUNT, m_cnt, "counter write");
    rnd = {$urandom, $urandom};
    wr_reg(PFS_MSR_ENABLE, rnd);
    rd_chk(PFS_MSR_ENABLE, {62'h0, rnd[1:0]}, "enable");
    // Productive cycles under random qualifiers
    repeat (300) begin
      act = 1'($urandom);
      prod = 1'($urandom);
      m_cnt += 64'(act & prod);
      wait_cyc(1);
    end
    {act, prod} = 2'h0;
    rd_chk(PFS_MSR_PCOUNT, m_cnt, "counter");
    // Live and latched limit bits
    for (int i = 0; i < 2; i++) begin
      {xd, cur} = (i == 0) ? 2'h1 : 2'h2;
      wait_cyc(6);
      rd_chk(PFS_MSR_THERMAL, 64'(2'h3) << (12 + 2 * i), "limit live");
      {xd, cur} = 2'h0;
      wait_cyc(6);
      wr_reg(PFS_MSR_THERMAL, '1);
      rd_chk(PFS_MSR_THERMAL, 64'(2'h2) << (12 + 2 * i), "limit log");
      wr_reg(PFS_MSR_THERMAL, 64'h0);
      rd_chk(PFS_MSR_THERMAL, 64'h0, "limit clear");
    end
    // Excursions below the floor
    wr_reg(PFS_MSR_ENABLE, 2'h2);
    dp = 8'h10;
    wait_cyc(20);
    dp = 8'h30;
    wait_cyc(60);
    rd_chk(PFS_MSR_STATUS, st_exp(), "short dip");
    dp = 8'h10;
    wait_lvt(1, 100);
    m_exc = 1'b1;
    rd_chk(PFS_MSR_STATUS, st_exp(), "excursion");
    wr_reg(PFS_MSR_STATUS, 64'h0);
    m_exc = 1'b0;
    wait_cyc(2000);
    rd_chk(PFS_MSR_STATUS, st_exp(), "rate limit");
    wait_lvt(2, 4500);
    m_exc = 1'b1;
    wait_cyc(4500);
    check("lvt while set", n_lvt, 2);
    rd_chk(PFS_MSR_STATUS, st_exp(), "still set");
    dp = 8'h30;
    // Guaranteed level changes, first masked
    gp = 8'h38;
    wait_cyc(2000);
    gp = 8'h40;
    wait_cyc(100);
    rd_chk(PFS_MSR_STATUS, st_exp(), "short change");
    gp = 8'h38;
    wait_cyc(4200);
    m_guar = 1'b1;
    rd_chk(PFS_MSR_STATUS, st_exp(), "guaranteed");
    check("reported", rg, gp);
    check("masked lvt", n_lvt, 2);
    wr_reg(PFS_MSR_ENABLE, 2'h1);
    wr_reg(PFS_MSR_STATUS, 64'h0);
    {m_guar, m_exc} = 2'h0;
    gp = 8'h30;
    wait_lvt(3, 8500);
    m_guar = 1'b1;
    rd_chk(PFS_MSR_STATUS, st_exp(), "guaranteed again");
    // Floor at lowest, then at highest capability
    mp = 8'h00;
    wait_cyc(100);
    rd_chk(PFS_MSR_STATUS, st_exp(), "floor lowest");
    mp = 8'hff;
    wait_cyc(60);
    m_exc = 1'b1;
    rd_chk(PFS_MSR_STATUS, st_exp(), "floor highest");
    check("lvt masked", n_lvt, 3);
    // Second reset in mid-run
    rst_b = 1'b0;
    wait_cyc(2);
    rst_b = 1'b1;
    wait_cyc(1);
    chk_zero();
    finish_test();
  end
endmodule : perf_feedback_status_notify_tb_top

bind pfs_top pfs_top_monitor #(.NOTIFY_SUPPORTED(NOTIFY_SUPPORTED)) u_mon (
  .clk(clk), .rst_b(rst_b), .msr_sel(msr_sel), .msr_rd(msr_rd), .msr_rdata_q(msr_rdata_q),
  .msr_rvalid_q(msr_rvalid_q), .thermal_lvt_req_q(thermal_lvt_req_q), .notify_cap_q(notify_cap_q),
  .reported_guaranteed_q(reported_guaranteed_q));

// *** test/pfs_top_monitor.sv ***
`timescale 1ns/1ps
module pfs_top_monitor
  import pfs_pkg::*;
#(
  parameter logic NOTIFY_SUPPORTED = 1'b1
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Register access port
  input wire pfs_pkg::pfs_msr_sel_t msr_sel,
  input wire logic                  msr_rd,
  input wire logic [63:0]           msr_rdata_q,
  input wire logic                  msr_rvalid_q,
  // Notification and capability
  input wire logic                  thermal_lvt_req_q,
  input wire logic                  notify_cap_q,
  input wire logic [7:0]            reported_guaranteed_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  sequence rd_req; msr_rd; endsequence
  sequence rd_ans; msr_rvalid_q; endsequence
  rd_answer_a: assert property (rd_req |=> rd_ans)
    else $error("read got no answer");
  rvalid_cause_a: assert property (msr_rvalid_q |-> $past(msr_rd))
    else $error("read answer without request");
  rdata_idle_a: assert property (!msr_rvalid_q |-> msr_rdata_q == 64'h0000_0000_0000_0000)
    else $error("read data not zero while idle");
  status_resv_a: assert property (rd_req and msr_sel == PFS_MSR_STATUS
    |=> msr_rdata_q[63:3] == '0 && !msr_rdata_q[1]) else $error("status reserved bits set");
  enable_resv_a: assert property (rd_req and msr_sel == PFS_MSR_ENABLE
    |=> msr_rdata_q[63:2] == '0) else $error("enable reserved bits set");
  lvt_pulse_a: assert property (thermal_lvt_req_q |=> !thermal_lvt_req_q [*3])
    else $error("notification request too long or too close");
  cap_report_a: assert property ($past(rst_b) |-> notify_cap_q == NOTIFY_SUPPORTED)
    else $error("capability report wrong");
  guar_hold_a: assert property ($changed(reported_guaranteed_q)
    |=> $stable(reported_guaranteed_q) [*8]) else $error("reported level changed too soon");
endmodule : pfs_top_monitor
